// *** oss_map.svh ***
`ifndef OSS_MAP_SVH
`define OSS_MAP_SVH
// channel count and result width
`define OSS_NCH 8
`define OSS_RW 18
`define OSS_SPW 3
`define OSS_CFGW 24
// span codes
`define OSS_SPAN_OFF 3'h0
// span bit that marks a bipolar range (codes 7,6,3,2)
`define OSS_BIP_BIT 1
// top result bit of an 18-bit code
`define OSS_MSB 17
// controller register offsets
`define OSS_A_CTRL 4'h0
`define OSS_A_SPAN 4'h1
`define OSS_A_STAT 4'h2
`define OSS_A_RES0 4'h8
// control bit positions
`define OSS_C_START 0
`define OSS_C_LVDS 1
`define OSS_C_NAP 2
`define OSS_C_PD 3
`define OSS_C_LANE_LO 4
`define OSS_C_LANE_HI 6
// no enabled channel left in the scan
`define OSS_NOCH 4'h8
// first trial code of a search, top bit set
`define OSS_TRIAL0 18'h20000
// link clock divider half period in mclk cycles
`define OSS_DIV_HALF 4'h2
`endif

// *** oss_pkg.sv ***
package oss_pkg;
	typedef logic [17:0] oss_res_t;
	typedef logic [2:0] oss_span_t;
	typedef enum logic [2:0]
	{
		OSS_IDLE = 3'h0,
		OSS_HOLD = 3'h1,
		OSS_SAR = 3'h3,
		OSS_NEXT = 3'h2,
		OSS_DONE = 3'h6
	} oss_state_t;
endpackage

// *** oss_link_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface oss_link_if;
	// link clock driven by the host
	logic linkClk;
	logic convertStart;
	logic [23:0] spanWord;
	logic lvdsSel;
	logic [2:0] laneSel;
	logic napReq;
	logic pdReq;
	// per-channel results, flat
	logic [143:0] results;
	logic busy;
	logic resultSeq;
	modport device (input linkClk, convertStart, spanWord, lvdsSel, laneSel, napReq, pdReq,
		output results, busy, resultSeq);
	modport host (output linkClk, convertStart, spanWord, lvdsSel, laneSel, napReq, pdReq,
		input results, busy, resultSeq);
endinterface
`default_nettype wire

// *** oss_device.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "oss_map.svh"
module oss_device
	import oss_pkg::*;
(
	// link side
	oss_link_if.device lnk,
	// analog stand-in: differential input, offset binary scaled
	input wire logic [143:0] sampleIn,
	input wire logic rstn
);
	// ------------------------------------------------------------
	// synchronisers and edge detect
	// ------------------------------------------------------------
	logic [1:0] rstSync_r;
	logic devRstn;
	logic [1:0] cnvSync_r;
	logic cnvPrev_r;
	logic [1:0] napSync_r;
	logic [1:0] pdSync_r;
	oss_state_t state_r;
	logic [2:0] ch_r;
	logic [4:0] bit_r;
	oss_res_t trial_r;
	logic [143:0] held_r;
	logic [23:0] span_r;
	logic [143:0] raw_r;
	logic [143:0] results_r;
	logic seq_r;
	logic [2:0] laneUse_r;
	logic lvdsUse_r;

	// format a raw code by span
	function automatic oss_res_t fmtRes(input oss_span_t sp, input oss_res_t raw);
		oss_res_t r;
		r = raw;
		if (sp == `OSS_SPAN_OFF)
			r = '0;
		else if (sp[`OSS_BIP_BIT])
			r[`OSS_MSB] = ~raw[`OSS_MSB];
		return r;
	endfunction

	// first enabled channel at or after a start index
	function automatic logic [3:0] nextCh(input logic [23:0] sp, input logic [3:0] from);
		logic [3:0] n;
		n = `OSS_NOCH;
		for (int i = 7; i >= 0; i--)
			if (4'(i) >= from && sp[i*3 +: 3] != `OSS_SPAN_OFF)
				n = 4'(i);
		return n;
	endfunction

	// pin inputs and host reset through two flops
	always_ff @(posedge lnk.linkClk)
	begin
		rstSync_r <= {rstSync_r[0], rstn};
		cnvSync_r <= {cnvSync_r[0], lnk.convertStart};
		napSync_r <= {napSync_r[0], lnk.napReq};
		pdSync_r <= {pdSync_r[0], lnk.pdReq};
	end

	always_ff @(posedge lnk.linkClk)
	begin
		if (!devRstn)
			cnvPrev_r <= 1'b0;
		else
			cnvPrev_r <= cnvSync_r[1];
	end

	logic cnvRise;
	logic asleep;
	logic [3:0] firstCh;
	logic [3:0] followCh;
	// reset released in step with the link clock
	assign devRstn = rstSync_r[1];
	assign cnvRise = cnvSync_r[1] & ~cnvPrev_r;
	assign asleep = napSync_r[1] | pdSync_r[1];
	assign firstCh = nextCh(span_r, 4'h0);
	assign followCh = nextCh(span_r, {1'b0, ch_r} + 4'h1);

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	always_ff @(posedge lnk.linkClk)
	begin
		if (!devRstn)
		begin
			state_r <= OSS_IDLE;
			ch_r <= 3'h0;
			bit_r <= 5'h0;
			trial_r <= '0;
			held_r <= '0;
			span_r <= '0;
			raw_r <= '0;
		end
		else
		begin
			case (state_r)
				OSS_IDLE:
				begin
					if (cnvRise && !asleep)
					begin
						held_r <= sampleIn;
						// 24-bit word, 3 bits per channel
						span_r <= lnk.spanWord;
						state_r <= OSS_HOLD;
					end
				end
				OSS_HOLD:
				begin
					if (firstCh == `OSS_NOCH)
						state_r <= OSS_DONE;
					else
					begin
						ch_r <= firstCh[2:0];
						state_r <= OSS_SAR;
					end
					raw_r <= '0;
					bit_r <= 5'(`OSS_MSB);
					trial_r <= oss_res_t'(`OSS_TRIAL0);
				end
				OSS_SAR:
				begin
					if (held_r[ch_r*18 +: 18] >= trial_r)
						raw_r[ch_r*18 +: 18] <= trial_r;
					else
						raw_r[ch_r*18 +: 18] <= trial_r ^ (oss_res_t'(18'h1) << bit_r);
					if (bit_r == 5'h0)
						state_r <= OSS_NEXT;
					else
					begin
						if (held_r[ch_r*18 +: 18] >= trial_r)
							trial_r <= trial_r | (oss_res_t'(18'h1) << (bit_r - 5'h1));
						else
							trial_r <= (trial_r ^ (oss_res_t'(18'h1) << bit_r))
								| (oss_res_t'(18'h1) << (bit_r - 5'h1));
						bit_r <= bit_r - 5'h1;
					end
				end
				OSS_NEXT:
				begin
					held_r[ch_r*18 +: 18] <= '0;
					trial_r <= oss_res_t'(`OSS_TRIAL0);
					bit_r <= 5'(`OSS_MSB);
					if (followCh == `OSS_NOCH)
						state_r <= OSS_DONE;
					else
					begin
						ch_r <= followCh[2:0];
						state_r <= OSS_SAR;
					end
				end
				OSS_DONE:
					state_r <= OSS_IDLE;
				default:
					state_r <= OSS_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// result staging
	// ------------------------------------------------------------
	always_ff @(posedge lnk.linkClk)
	begin
		if (!devRstn)
		begin
			results_r <= '0;
			seq_r <= 1'b0;
		end
		else if (state_r == OSS_DONE)
		begin
			for (int i = 0; i < 8; i++)
				results_r[i*18 +: 18] <= fmtRes(span_r[i*3 +: 3], raw_r[i*18 +: 18]);
			seq_r <= ~seq_r;
		end
	end

	// interface mode and lane count taken
	always_ff @(posedge lnk.linkClk)
	begin
		if (!devRstn)
		begin
			lvdsUse_r <= 1'b0;
			laneUse_r <= 3'h0;
		end
		else if (state_r == OSS_IDLE)
		begin
			lvdsUse_r <= lnk.lvdsSel;
			laneUse_r <= lnk.lvdsSel ? 3'h0 : lnk.laneSel;
		end
	end

	assign lnk.results = results_r;
	assign lnk.resultSeq = seq_r;
	assign lnk.busy = (state_r != OSS_IDLE);
endmodule
`default_nettype wire

// *** oss_host.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "oss_map.svh"
module oss_host
	import oss_pkg::*;
(
	// link side
	oss_link_if.host lnk,
	// system
	input wire logic mclk,
	input wire logic rstn,
	// software port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata
);
	logic [3:0] div_r;
	logic lclk_r;
	logic rstLow_r;
	logic [31:0] ctrl_r;
	logic [23:0] span_r;
	logic cnv_r;
	logic [1:0] seqSync_r;
	logic seqPrev_r;
	logic [1:0] busySync_r;
	logic done_r;
	logic [31:0] rdata_r;

	// link clock divider; keeps toggling in reset so the far end resets too
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			div_r <= 4'h0;
			if (rstLow_r)
				lclk_r <= ~lclk_r;
			else
				lclk_r <= 1'b0;
			rstLow_r <= 1'b1;
		end
		else if (div_r == `OSS_DIV_HALF - 4'h1)
		begin
			div_r <= 4'h0;
			lclk_r <= ~lclk_r;
		end
		else
			div_r <= div_r + 4'h1;
	end

	// control and span registers
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			ctrl_r <= '0;
			span_r <= '0;
		end
		else if (wr && addr == `OSS_A_CTRL)
			ctrl_r <= wdata & 32'hFFFFFFFE;
		else if (wr && addr == `OSS_A_SPAN)
			span_r <= wdata[23:0];
	end

	// start pulse held high for several link clocks
	logic [3:0] cnvCnt_r;
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			cnv_r <= 1'b0;
			cnvCnt_r <= 4'h0;
		end
		else if (wr && addr == `OSS_A_CTRL && wdata[`OSS_C_START])
		begin
			cnv_r <= 1'b1;
			cnvCnt_r <= 4'hF;
		end
		else if (cnvCnt_r != 4'h0)
			cnvCnt_r <= cnvCnt_r - 4'h1;
		else
			cnv_r <= 1'b0;
	end

	// status crossing and sticky done
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			seqSync_r <= 2'h0;
			seqPrev_r <= 1'b0;
			busySync_r <= 2'h0;
			done_r <= 1'b0;
		end
		else
		begin
			seqSync_r <= {seqSync_r[0], lnk.resultSeq};
			busySync_r <= {busySync_r[0], lnk.busy};
			seqPrev_r <= seqSync_r[1];
			// set wins over read-clear
			if (seqSync_r[1] != seqPrev_r)
				done_r <= 1'b1;
			else if (rd && addr == `OSS_A_STAT)
				done_r <= 1'b0;
		end
	end

	// read mux, data next cycle
	always_ff @(posedge mclk)
	begin
		if (!rstn)
			rdata_r <= '0;
		else if (rd)
		begin
			if (addr == `OSS_A_CTRL)
				rdata_r <= ctrl_r;
			else if (addr == `OSS_A_SPAN)
				rdata_r <= {8'h00, span_r};
			else if (addr == `OSS_A_STAT)
				rdata_r <= {30'h0, busySync_r[1], done_r};
			else if (addr >= `OSS_A_RES0)
				rdata_r <= {14'h0, lnk.results[addr[2:0]*18 +: 18]};
			else
				rdata_r <= '0;
		end
	end

	assign rdata = rdata_r;
	assign lnk.linkClk = lclk_r;
	assign lnk.convertStart = cnv_r;
	assign lnk.spanWord = span_r;
	assign lnk.lvdsSel = ctrl_r[`OSS_C_LVDS];
	assign lnk.laneSel = ctrl_r[`OSS_C_LANE_HI:`OSS_C_LANE_LO];
	assign lnk.napReq = ctrl_r[`OSS_C_NAP];
	assign lnk.pdReq = ctrl_r[`OSS_C_PD];
endmodule
`default_nettype wire

// *** oss_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module oss_asserts
(
	// link clock and reset
	input wire logic linkClk,
	input wire logic rstn,
	// host to device
	input wire logic convertStart,
	input wire logic [23:0] spanWord,
	input wire logic napReq,
	input wire logic pdReq,
	// device to host
	input wire logic [143:0] results,
	input wire logic busy,
	input wire logic resultSeq
);
	default clocking cb @(posedge linkClk); endclocking
	default disable iff (!rstn);
	// start edge seen while idle and awake
	sequence s_start;
		$rose(convertStart) && !busy && !napReq && !pdReq;
	endsequence
	// new results flagged shortly after
	sequence s_publish;
		##[0:4] $changed(resultSeq);
	endsequence
	property p_hold;
		s_start |-> ##[1:6] busy;
	endproperty
	a_hold: assert property (p_hold) else $error("no busy after start");
	property p_run;
		$rose(busy) && (spanWord != 24'h000000) |-> busy[*8];
	endproperty
	a_run: assert property (p_run) else $error("conversion too short");
	property p_end;
		$rose(busy) |-> ##[8:300] !busy;
	endproperty
	a_end: assert property (p_end) else $error("conversion never ends");
	property p_pub;
		$fell(busy) |-> s_publish;
	endproperty
	a_pub: assert property (p_pub) else $error("results not published");
	property p_keep;
		busy && $past(busy) |-> $stable(results);
	endproperty
	a_keep: assert property (p_keep) else $error("results moved mid conversion");
	property p_tag;
		$changed(results) |-> $changed(resultSeq);
	endproperty
	a_tag: assert property (p_tag) else $error("results changed unflagged");
	property p_late;
		$changed(resultSeq) |-> !busy;
	endproperty
	a_late: assert property (p_late) else $error("published while busy");
	property p_sleep;
		(napReq || pdReq) && !busy |=> !busy;
	endproperty
	a_sleep: assert property (p_sleep) else $error("converted while asleep");
endmodule
`default_nettype wire

// *** oss_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "oss_map.svh"
module oss_bench
	import oss_pkg::*;
;
	logic mclk, rstn, wr, rd;
	logic [3:0] addr;
	logic [31:0] wdata, rdata;
	logic [143:0] smpl;
	int fails, tests_run, n8, n1;
	// -------------------
	// ends and checker
	// -------------------
	oss_link_if lnk();
	oss_device oss_device_i(.lnk(lnk), .sampleIn(smpl), .rstn(rstn));
	oss_host oss_host_i(.lnk(lnk), .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata));
	oss_asserts oss_asserts_i(.linkClk(lnk.linkClk), .rstn(rstn),
		.convertStart(lnk.convertStart), .spanWord(lnk.spanWord),
		.napReq(lnk.napReq), .pdReq(lnk.pdReq),
		.results(lnk.results), .busy(lnk.busy), .resultSeq(lnk.resultSeq));
	// system clock
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// -------------------
	// helpers
	// -------------------
	task automatic close_out();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// poll status until done, bounded
	task automatic wait_done(output int n);
		logic [31:0] s;
		for (n = 0; n < 1000; n++)
		begin
			rreg(`OSS_A_STAT, s);
			if (s[0] === 1'b1)
				return;
		end
		fails++;
		close_out();
	endtask
	function automatic oss_res_t smp(int i, int k);
		return {i[0] ^ k[0], i[2:0], k[1:0], 12'hA5C};
	endfunction
	// expected code from span and offset-binary sample
	function automatic oss_res_t expv(oss_span_t c, oss_res_t s);
		if (c == `OSS_SPAN_OFF)
			return 18'h00000;
		return c[`OSS_BIP_BIT] ? {~s[17], s[16:0]} : s;
	endfunction
	// one conversion with span pattern k, all results checked
	task automatic conv(input int k, output int n);
		logic [23:0] sw;
		logic [31:0] v;
		oss_span_t c [8];
		for (int i = 0; i < 8; i++)
		begin
			c[i] = oss_span_t'(k == 0 ? i : k == 1 ? 7 - i : (i == 0 ? 7 : 0));
			sw[3 * i +: 3] = c[i];
			smpl[18 * i +: 18] <= smp(i, k);
		end
		wreg(`OSS_A_SPAN, {8'h00, sw});
		wreg(`OSS_A_CTRL, 32'h00000001);
		wait_done(n);
		for (int i = 0; i < 8; i++)
		begin
			rreg(`OSS_A_RES0 + 4'(i), v);
			chk(v, {14'h0000, expv(c[i], smp(i, k))});
		end
	endtask
	// start refused while asleep, mode pins follow control
	task automatic s_sleep();
		logic [31:0] v;
		wreg(`OSS_A_CTRL, 32'h00000076);
		wreg(`OSS_A_CTRL, 32'h00000077);
		chk({27'h0, lnk.lvdsSel, lnk.laneSel, lnk.napReq}, 32'h0000001F);
		repeat (800) @(posedge mclk);
		rreg(`OSS_A_STAT, v);
		chk(v, 32'h00000000);
		wreg(`OSS_A_CTRL, 32'h00000008);
		wreg(`OSS_A_CTRL, 32'h00000009);
		repeat (800) @(posedge mclk);
		rreg(`OSS_A_STAT, v);
		chk(v, 32'h00000000);
		wreg(`OSS_A_CTRL, 32'h00000000);
		rreg(4'h5, v);
		chk(v, 32'h00000000);
	endtask
	// -------------------
	// main sequence
	// -------------------
	initial
	begin
		int n;
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 32'h00000000;
		smpl = '0;
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		repeat (10) @(posedge mclk);
		conv(0, n8);
		conv(1, n);
		conv(2, n1);
		chk(32'(n1 < n8), 32'h00000001);
		s_sleep();
		conv(1, n);
		close_out();
	end
endmodule
`default_nettype wire
